// >>> design/chtp_pkg.sv
package chtp_pkg;

  // direct register offsets
  localparam logic [3:0] OFS_INDEX      = 4'h0;
  localparam logic [3:0] OFS_IND_LOW    = 4'h2;
  localparam logic [3:0] OFS_IND_HIGH   = 4'h3;
  localparam logic [3:0] OFS_DEBUG      = 4'h4;
  localparam logic [3:0] OFS_STATUS     = 4'h5;
  localparam logic [3:0] OFS_SAMPLE     = 4'h6;
  localparam logic [3:0] OFS_SPARE7     = 4'h7;
  localparam logic [3:0] OFS_PLAY_SETUP = 4'h8;
  localparam logic [3:0] OFS_CAP_SETUP  = 4'h9;
  localparam logic [3:0] OFS_SPARE10    = 4'hA;
  localparam logic [3:0] OFS_SPARE11    = 4'hB;

  // index value that exposes the low-byte holding latch
  localparam logic [5:0] LATCH_INDEX    = 6'h00;

  // status register bit positions
  localparam int ST_PB_HALF_ROOM = 7;
  localparam int ST_PB_READY     = 6;
  localparam int ST_PB_SIDE      = 5;
  localparam int ST_PB_BYTE_HALF = 4;
  localparam int ST_CAP_HALF     = 3;
  localparam int ST_CAP_READY    = 2;
  localparam int ST_CAP_SIDE     = 1;
  localparam int ST_CAP_BYTE_HALF = 0;
  // debug register bit positions
  localparam int DBG_PB_UNDERRUN = 5;
  localparam int DBG_CAP_OVERRUN = 4;
  // index register bit 7: port ready
  localparam int IDX_READY       = 7;

  // fifo thresholds in bytes
  localparam logic [6:0] HALF_ROOM_BYTES = 7'h20;
  localparam logic [6:0] GROUP_BYTES     = 7'h04;
  localparam logic [1:0] LAST_LANE       = 2'h3;

  // {format[1:0], compand} codes
  localparam logic [2:0] FMT_U8    = 3'h0;
  localparam logic [2:0] FMT_MULAW = 3'h1;
  localparam logic [2:0] FMT_LE16  = 3'h2;
  localparam logic [2:0] FMT_ALAW  = 3'h3;
  localparam logic [2:0] FMT_BE16  = 3'h6;

  // playback and capture setup share one layout
  typedef struct packed {
    logic       drq_block;
    logic       dac_zero;
    logic [1:0] format_code;
    logic       compand;
    logic       stereo;
    logic       xfer_pio;
    logic       run;
  } chtp_setup_type;

  localparam chtp_setup_type SETUP_RESET = 8'h00;

  typedef struct packed {
    logic legal;
    logic wide;
    logic upper;
    logic left;
  } chtp_lane_type;

  typedef struct packed {
    logic [1:0] idx;
    logic       done;
  } chtp_cursor_type;

  localparam chtp_cursor_type CURSOR_RESET = 3'h0;

  typedef struct packed {
    logic [5:0]     index;
    logic [7:0]     latch;
    chtp_setup_type play_setup;
    chtp_setup_type cap_setup;
    logic [31:0]    pb_group;
    logic           pb_valid;
    logic [31:0]    cap_group;
    logic           cap_have;
    logic           cap_taken;
    logic [7:0]     rdata;
    logic           ind_wr;
    logic [15:0]    ind_wdata;
    logic           pb_under;
    logic           pb_armed;
    logic           cap_over;
    logic           cap_armed;
    logic [15:0]    dac_out;
  } chtp_port_state_type;

  localparam chtp_port_state_type PORT_RESET = '0;

endpackage

// >>> design/chtp_byte_cursor.sv
module chtp_byte_cursor (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // control
  input  wire logic                     restart,
  input  wire logic                     step,
  // position
  output chtp_pkg::chtp_cursor_type     pos
);

  chtp_pkg::chtp_cursor_type s_q;
  chtp_pkg::chtp_cursor_type s_d;

  always_comb begin
    s_d = s_q;
    if (restart) begin
      s_d = chtp_pkg::CURSOR_RESET;
    end else if (step && !s_q.done) begin
      // parks on the last lane; later steps leave it there
      if (s_q.idx == chtp_pkg::LAST_LANE) begin
        s_d.done = 1'b1;
      end else begin
        s_d.idx = s_q.idx + 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= chtp_pkg::CURSOR_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign pos = s_q;

endmodule

// >>> design/chtp_lane_decode.sv
module chtp_lane_decode (
  // format and lane
  input  chtp_pkg::chtp_setup_type  setup,
  input  wire logic [1:0]           lane,
  // meaning of the lane
  output chtp_pkg::chtp_lane_type   info
);

  logic [2:0] code;

  assign code = {setup.format_code, setup.compand};

  always_comb begin
    info.legal = (code == chtp_pkg::FMT_U8) || (code == chtp_pkg::FMT_MULAW) ||
                 (code == chtp_pkg::FMT_LE16) || (code == chtp_pkg::FMT_ALAW) ||
                 (code == chtp_pkg::FMT_BE16);
    info.wide  = (code == chtp_pkg::FMT_LE16) || (code == chtp_pkg::FMT_BE16);
    if (!info.wide) begin
      // 8-bit: every lane is a whole sample, reported as upper
      info.upper = 1'b1;
      info.left  = !setup.stereo || !lane[0];
    end else begin
      info.upper = (code == chtp_pkg::FMT_BE16) ? !lane[0] : lane[0];
      info.left  = !setup.stereo || !lane[1];
    end
  end

endmodule

// >>> design/chtp_host_port.sv
module chtp_host_port #(
  parameter int ROOM_W = 7
) (
  // clock and reset
  input  wire logic                CORE_CLK,
  input  wire logic                RST_N,
  // host register port
  input  wire logic [3:0]          HOST_ADDR,
  input  wire logic [7:0]          HOST_WDATA,
  input  wire logic                HOST_WR,
  input  wire logic                HOST_RD,
  output logic      [7:0]          HOST_RDATA,
  // host dma
  output logic                     DMA_PLAY_REQ,
  input  wire logic                DMA_PLAY_ACK,
  output logic                     DMA_CAP_REQ,
  input  wire logic                DMA_CAP_ACK,
  input  wire logic                CODEC_IRQ,
  // playback fifo
  input  wire logic [ROOM_W-1:0]   PB_FIFO_ROOM,
  input  wire logic                PB_FIFO_EMPTY,
  output logic      [31:0]         PB_GROUP_DATA,
  output logic                     PB_GROUP_VALID,
  // capture fifo
  input  wire logic [ROOM_W-1:0]   CAP_FIFO_FILL,
  input  wire logic                CAP_FIFO_FULL,
  input  wire logic [31:0]         CAP_GROUP_DATA,
  input  wire logic                CAP_GROUP_VALID,
  output logic                     CAP_GROUP_READY,
  output logic                     CAP_GROUP_TAKEN,
  // converter side
  input  wire logic                SAMPLE_TICK,
  input  wire logic [15:0]         DAC_SAMPLE_IN,
  output logic      [15:0]         DAC_SAMPLE_OUT,
  // indirect register file
  output logic      [5:0]          IND_ADDR,
  output logic      [15:0]         IND_WDATA,
  output logic                     IND_WR,
  input  wire logic [15:0]         IND_RDATA
);

  chtp_pkg::chtp_port_state_type s_q;
  chtp_pkg::chtp_port_state_type s_d;

  chtp_pkg::chtp_cursor_type pb_pos;
  chtp_pkg::chtp_cursor_type cap_pos;
  chtp_pkg::chtp_lane_type   pb_lane;
  chtp_pkg::chtp_lane_type   cap_lane;

  logic       pb_restart;
  logic       pb_step;
  logic       cap_restart;
  logic       cap_step;
  logic       pb_byte_in;
  logic       cap_byte_out;
  logic       pb_send;
  logic       cap_load;
  logic       pb_room4;
  logic       drq_hold;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] cap_byte;
  logic [7:0] status_byte;

  // a dma acknowledge claims the strobe, the address is not decoded then
  assign reg_wr = HOST_WR && !DMA_PLAY_ACK;
  assign reg_rd = HOST_RD && !DMA_CAP_ACK;

  assign pb_room4 = PB_FIFO_ROOM >= chtp_pkg::GROUP_BYTES;

  // bytes enter playback only on the selected path while running
  always_comb begin
    pb_byte_in = 1'b0;
    if (s_q.play_setup.run) begin
      if (s_q.play_setup.xfer_pio) begin
        pb_byte_in = reg_wr && (HOST_ADDR == chtp_pkg::OFS_SAMPLE);
      end else begin
        pb_byte_in = HOST_WR && DMA_PLAY_ACK;
      end
    end
  end

  always_comb begin
    cap_byte_out = 1'b0;
    if (s_q.cap_setup.run) begin
      if (s_q.cap_setup.xfer_pio) begin
        cap_byte_out = reg_rd && (HOST_ADDR == chtp_pkg::OFS_SAMPLE);
      end else begin
        cap_byte_out = HOST_RD && DMA_CAP_ACK;
      end
    end
  end

  // a full group waits for room, then leaves as one unit
  assign pb_send    = pb_pos.done && pb_room4;
  assign pb_step    = pb_byte_in;
  assign pb_restart = pb_send || !s_q.play_setup.run;

  assign cap_load    = CAP_GROUP_VALID && CAP_GROUP_READY;
  assign cap_step    = cap_byte_out;
  assign cap_restart = cap_load || !s_q.cap_setup.run;

  // a blocked request only waits; the data path stays intact
  assign drq_hold = s_q.play_setup.drq_block && CODEC_IRQ;

  chtp_byte_cursor u_pb_cursor (
    .clk     (CORE_CLK),
    .rst_n   (RST_N),
    .restart (pb_restart),
    .step    (pb_step),
    .pos     (pb_pos)
  );

  chtp_byte_cursor u_cap_cursor (
    .clk     (CORE_CLK),
    .rst_n   (RST_N),
    .restart (cap_restart),
    .step    (cap_step),
    .pos     (cap_pos)
  );

  chtp_lane_decode u_pb_lane (
    .setup (s_q.play_setup),
    .lane  (pb_pos.idx),
    .info  (pb_lane)
  );

  chtp_lane_decode u_cap_lane (
    .setup (s_q.cap_setup),
    .lane  (cap_pos.idx),
    .info  (cap_lane)
  );

  assign cap_byte = s_q.cap_group[{cap_pos.idx, 3'h0} +: 8];

  always_comb begin
    status_byte = 8'h00;
    status_byte[chtp_pkg::ST_PB_HALF_ROOM] =
      PB_FIFO_ROOM >= chtp_pkg::HALF_ROOM_BYTES;
    status_byte[chtp_pkg::ST_PB_READY] = pb_room4 && !pb_pos.done;
    status_byte[chtp_pkg::ST_PB_SIDE] = pb_lane.left;
    status_byte[chtp_pkg::ST_PB_BYTE_HALF] = pb_lane.upper;
    status_byte[chtp_pkg::ST_CAP_HALF] = CAP_FIFO_FILL >= chtp_pkg::HALF_ROOM_BYTES;
    status_byte[chtp_pkg::ST_CAP_READY] = s_q.cap_have;
    status_byte[chtp_pkg::ST_CAP_SIDE] = cap_lane.left;
    status_byte[chtp_pkg::ST_CAP_BYTE_HALF] = cap_lane.upper;
  end

  always_comb begin
    s_d = s_q;
    s_d.pb_valid  = 1'b0;
    s_d.cap_taken = 1'b0;
    s_d.ind_wr    = 1'b0;

    // playback assembly: lanes past the last one are dropped by the cursor
    if (pb_byte_in && !pb_pos.done) begin
      s_d.pb_group[{pb_pos.idx, 3'h0} +: 8] = HOST_WDATA;
    end
    if (pb_send) begin
      s_d.pb_valid = 1'b1;
    end

    // capture hand-off: the group is gone once its last lane is read
    if (cap_load) begin
      s_d.cap_group = CAP_GROUP_DATA;
      s_d.cap_have  = 1'b1;
    end else if (cap_step && !cap_pos.done && cap_pos.idx == chtp_pkg::LAST_LANE) begin
      s_d.cap_have  = 1'b0;
      s_d.cap_taken = 1'b1;
    end

    // underrun: armed on the first empty tick, raised on the next; set wins
    if (SAMPLE_TICK && PB_FIFO_EMPTY && s_q.play_setup.run) begin
      s_d.pb_armed = 1'b1;
      if (s_q.pb_armed) begin
        s_d.pb_under = 1'b1;
      end
    end else if (pb_send) begin
      s_d.pb_armed = 1'b0;
      s_d.pb_under = 1'b0;
    end

    // overrun mirrors underrun on the capture side
    if (SAMPLE_TICK && CAP_FIFO_FULL && s_q.cap_setup.run) begin
      s_d.cap_armed = 1'b1;
      if (s_q.cap_armed) begin
        s_d.cap_over = 1'b1;
      end
    end else if (s_d.cap_taken) begin
      s_d.cap_armed = 1'b0;
      s_d.cap_over  = 1'b0;
    end

    // converter feed; while starved, hold or force zero
    if (SAMPLE_TICK) begin
      if (!s_q.pb_under) begin
        s_d.dac_out = DAC_SAMPLE_IN;
      end else if (s_q.play_setup.dac_zero) begin
        s_d.dac_out = 16'h0000;
      end
    end

    // register writes
    if (reg_wr) begin
      unique case (HOST_ADDR)
        chtp_pkg::OFS_INDEX: begin
          s_d.index = HOST_WDATA[5:0];
        end
        chtp_pkg::OFS_IND_LOW: begin
          s_d.latch = HOST_WDATA;
        end
        chtp_pkg::OFS_IND_HIGH: begin
          s_d.ind_wdata = {HOST_WDATA, s_q.latch};
          s_d.ind_wr    = 1'b1;
        end
        chtp_pkg::OFS_PLAY_SETUP: begin
          s_d.play_setup = HOST_WDATA;
        end
        chtp_pkg::OFS_CAP_SETUP: begin
          s_d.cap_setup = {1'b0, HOST_WDATA[6:0]};
        end
        // spare offsets and read-only registers ignore writes
        default: begin
        end
      endcase
    end

    // read data, one cycle behind the strobe
    if (cap_byte_out) begin
      s_d.rdata = cap_byte;
    end else if (reg_rd) begin
      unique case (HOST_ADDR)
        chtp_pkg::OFS_INDEX: begin
          s_d.rdata = {1'b1, 1'b0, s_q.index};
        end
        chtp_pkg::OFS_IND_LOW: begin
          if (s_q.index == chtp_pkg::LATCH_INDEX) begin
            s_d.rdata = s_q.latch;
          end else begin
            s_d.rdata = IND_RDATA[7:0];
          end
        end
        chtp_pkg::OFS_IND_HIGH: begin
          s_d.rdata = IND_RDATA[15:8];
        end
        chtp_pkg::OFS_DEBUG: begin
          s_d.rdata = 8'h00;
          s_d.rdata[chtp_pkg::DBG_PB_UNDERRUN] = s_q.pb_under;
          s_d.rdata[chtp_pkg::DBG_CAP_OVERRUN] = s_q.cap_over;
        end
        chtp_pkg::OFS_STATUS: begin
          s_d.rdata = status_byte;
        end
        chtp_pkg::OFS_SAMPLE: begin
          // capture idle or on dma: no pointer movement
          s_d.rdata = cap_byte;
        end
        chtp_pkg::OFS_PLAY_SETUP: begin
          s_d.rdata = s_q.play_setup;
        end
        chtp_pkg::OFS_CAP_SETUP: begin
          s_d.rdata = s_q.cap_setup;
        end
        default: begin
          s_d.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      s_q <= chtp_pkg::PORT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // dma requests: path selected, running, space or data there, not held
  assign DMA_PLAY_REQ = s_q.play_setup.run && !s_q.play_setup.xfer_pio &&
                        !pb_pos.done && pb_room4 && !drq_hold;
  assign DMA_CAP_REQ  = s_q.cap_setup.run && !s_q.cap_setup.xfer_pio &&
                        s_q.cap_have && !drq_hold;

  assign CAP_GROUP_READY = s_q.cap_setup.run && !s_q.cap_have;
  assign CAP_GROUP_TAKEN = s_q.cap_taken;
  assign PB_GROUP_DATA   = s_q.pb_group;
  assign PB_GROUP_VALID  = s_q.pb_valid;
  assign HOST_RDATA      = s_q.rdata;
  assign DAC_SAMPLE_OUT  = s_q.dac_out;
  assign IND_ADDR        = s_q.index;
  assign IND_WDATA       = s_q.ind_wdata;
  assign IND_WR          = s_q.ind_wr;

endmodule

// >>> verif/chtp_codec_model.sv
module chtp_codec_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // playback fifo
  input  wire logic        push,
  input  wire logic        drain,
  output logic      [6:0]  room,
  output logic             empty,
  // capture group source
  input  wire logic        offer,
  input  wire logic [31:0] offer_data,
  input  wire logic        ready,
  output logic      [31:0] cap_data,
  output logic             cap_valid,
  // indirect register file
  input  wire logic [5:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  output logic      [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] regs [64];
  logic [6:0]  level;
  assign room  = 7'h40 - level;
  assign empty = level == 7'h00;
  // write-through: a read in the commit cycle already sees the new word
  assign rdata = wr ? wdata : regs[addr];
  always @(posedge clk) begin
    if (wr) begin
      regs[addr] <= wdata;
    end
    if (!rst_n) begin
      level     <= 7'h00;
      cap_valid <= 1'b0;
      cap_data  <= 32'hA5A5A5A5;
    end else begin
      // fifo only moves whole 4-byte groups
      level <= level + (push ? 7'h04 : 7'h00) - ((drain && level != 7'h00) ? 7'h04 : 7'h00);
      if (cap_valid && ready) begin
        cap_valid <= 1'b0;
        // taken data is not left looking valid
        cap_data  <= ~cap_data;
      end
      if (offer) begin
        cap_valid <= 1'b1;
        cap_data  <= offer_data;
      end
    end
  end
endmodule

// >>> verif/chtp_host_port_properties.sv
module chtp_props #(
  parameter int ROOM_W = 7
) (
  input wire logic              CORE_CLK,
  input wire logic              RST_N,
  input wire logic [3:0]        HOST_ADDR,
  input wire logic [7:0]        HOST_WDATA,
  input wire logic              HOST_WR,
  input wire logic              HOST_RD,
  input wire logic [7:0]        HOST_RDATA,
  input wire logic              DMA_PLAY_ACK,
  input wire logic              DMA_CAP_ACK,
  input wire logic [ROOM_W-1:0] PB_FIFO_ROOM,
  input wire logic              PB_GROUP_VALID,
  input wire logic              CAP_GROUP_READY,
  input wire logic              CAP_GROUP_TAKEN,
  input wire logic [5:0]        IND_ADDR,
  input wire logic [15:0]       IND_WDATA,
  input wire logic              IND_WR
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_wr(a); HOST_WR && !DMA_PLAY_ACK && HOST_ADDR == a; endsequence
  sequence s_rd(a); HOST_RD && !DMA_CAP_ACK && HOST_ADDR == a; endsequence
  sequence s_latch; s_wr(4'h2) ##1 (s_rd(4'h2) ##0 IND_ADDR == 6'h00); endsequence
  property p_commit; s_wr(4'h3) |=> IND_WR && IND_WDATA[15:8] == $past(HOST_WDATA); endproperty
  a_commit: assert property (p_commit) else $error("high byte did not commit");
  property p_index; s_wr(4'h0) |=> IND_ADDR == 6'($past(HOST_WDATA)); endproperty
  a_index: assert property (p_index) else $error("index not taken");
  property p_idx_rd; s_rd(4'h0) |=> HOST_RDATA == {2'b10, $past(IND_ADDR)}; endproperty
  a_idx_rd: assert property (p_idx_rd) else $error("index readback wrong");
  property p_latch; s_latch |=> HOST_RDATA == $past(HOST_WDATA, 2); endproperty
  a_latch: assert property (p_latch) else $error("latch readback wrong");
  property p_half; s_rd(4'h5) |=> HOST_RDATA[7] == ($past(PB_FIFO_ROOM) >= ROOM_W'(32)); endproperty
  a_half: assert property (p_half) else $error("half room flag wrong");
  property p_spare;
    HOST_RD && !DMA_CAP_ACK && HOST_ADDR inside {4'h7, 4'hA, 4'hB} |=> HOST_RDATA == 8'h00;
  endproperty
  a_spare: assert property (p_spare) else $error("spare offset read nonzero");
  property p_push; PB_GROUP_VALID |-> ($past(PB_FIFO_ROOM) >= ROOM_W'(4)) ##1 !PB_GROUP_VALID; endproperty
  a_push: assert property (p_push) else $error("group push without room");
  property p_taken; CAP_GROUP_TAKEN |-> CAP_GROUP_READY ##1 !CAP_GROUP_TAKEN; endproperty
  a_taken: assert property (p_taken) else $error("capture take pulse wrong");
endmodule

bind chtp_host_port chtp_props #(.ROOM_W(ROOM_W)) u_props (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .HOST_ADDR(HOST_ADDR), .HOST_WDATA(HOST_WDATA),
  .HOST_WR(HOST_WR), .HOST_RD(HOST_RD), .HOST_RDATA(HOST_RDATA), .DMA_PLAY_ACK(DMA_PLAY_ACK),
  .DMA_CAP_ACK(DMA_CAP_ACK), .PB_FIFO_ROOM(PB_FIFO_ROOM), .PB_GROUP_VALID(PB_GROUP_VALID),
  .CAP_GROUP_READY(CAP_GROUP_READY), .CAP_GROUP_TAKEN(CAP_GROUP_TAKEN),
  .IND_ADDR(IND_ADDR), .IND_WDATA(IND_WDATA), .IND_WR(IND_WR));

// >>> verif/chtp_host_port_tb_top.sv
module chtp_host_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] SPARE [3] = '{4'h7, 4'hA, 4'hB};
  localparam logic [2:0] FMTS [5] = '{chtp_pkg::FMT_U8, chtp_pkg::FMT_MULAW,
    chtp_pkg::FMT_LE16, chtp_pkg::FMT_ALAW, chtp_pkg::FMT_BE16};
  logic        clk, rst_n, wr, rd, pack, cack, irq, tick, offer, rd_seen;
  logic        preq, creq, pempty, pval, cval, crdy, ctaken, iwr;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, s;
  logic [6:0]  proom;
  logic [5:0]  iaddr;
  logic [15:0] dac_in, dac_out, iwdata, irdata, e;
  logic [31:0] pdata, cdata, odata, g;
  logic [15:0] exp_rd_q [$];
  logic [31:0] exp_grp_q [$];
  logic [31:0] seed = 32'h38;
  int          err_total = 0;
  int          n_compared = 0;
  int          n_taken = 0;

  chtp_host_port dut (
    .CORE_CLK(clk), .RST_N(rst_n), .HOST_ADDR(addr), .HOST_WDATA(wdata), .HOST_WR(wr),
    .HOST_RD(rd), .HOST_RDATA(rdata), .DMA_PLAY_REQ(preq), .DMA_PLAY_ACK(pack),
    .DMA_CAP_REQ(creq), .DMA_CAP_ACK(cack), .CODEC_IRQ(irq), .PB_FIFO_ROOM(proom),
    .PB_FIFO_EMPTY(pempty), .PB_GROUP_DATA(pdata), .PB_GROUP_VALID(pval),
    .CAP_FIFO_FILL(7'h10), .CAP_FIFO_FULL(1'b0), .CAP_GROUP_DATA(cdata),
    .CAP_GROUP_VALID(cval), .CAP_GROUP_READY(crdy), .CAP_GROUP_TAKEN(ctaken),
    .SAMPLE_TICK(tick), .DAC_SAMPLE_IN(dac_in), .DAC_SAMPLE_OUT(dac_out),
    .IND_ADDR(iaddr), .IND_WDATA(iwdata), .IND_WR(iwr), .IND_RDATA(irdata));
  chtp_codec_model codec (
    .clk(clk), .rst_n(rst_n), .push(pval), .drain(tick), .room(proom), .empty(pempty),
    .offer(offer), .offer_data(odata), .ready(crdy), .cap_data(cdata), .cap_valid(cval),
    .addr(iaddr), .wdata(iwdata), .wr(iwr), .rdata(irdata));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(logic w, logic ack, logic [3:0] a, logic [7:0] d);
    @(negedge clk);
    wr = w;
    rd = !w;
    pack = ack & w;
    cack = ack & !w;
    addr = a;
    wdata = d;
  endtask
  task automatic get(logic [3:0] a, logic [7:0] m, logic [7:0] x, logic ack = 1'b0);
    exp_rd_q.push_back({m, x});
    bus(1'b0, ack, a, 8'h00);
  endtask
  task automatic idle(int n = 1);
    @(negedge clk);
    {wr, rd, pack, cack} = 4'h0;
    repeat (n - 1) @(negedge clk);
  endtask
  task automatic pulse_tick(int n);
    repeat (n) begin
      @(negedge clk);
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
    end
  endtask
  // fifth byte differs so a leak into the next group shows
  task automatic put_group(logic ack, logic [31:0] v);
    exp_grp_q.push_back(v);
    for (int b = 0; b < 5; b++) bus(1'b1, ack, 4'h6, b < 4 ? v[8*b +: 8] : ~v[7:0]);
  endtask
  task automatic offer_group(logic [31:0] v);
    odata = v;
    offer = 1'b1;
    @(negedge clk);
    offer = 1'b0;
    idle(2);
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) begin
    if (rd_seen) begin
      e = exp_rd_q.pop_front();
      chk("read data", 32'(rdata & e[15:8]), 32'(e[7:0] & e[15:8]));
    end
    if (ctaken) n_taken++;
    if (pval) begin
      if (exp_grp_q.size() == 0) chk("extra group", 32'h1, 32'h0);
      else chk("group data", pdata, exp_grp_q.pop_front());
    end
  end

  // run needs well under 1000 cycles
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    {wr, rd, pack, cack, irq, tick, offer} = 7'h00;
    {addr, wdata, odata} = 44'h0;
    dac_in = 16'hA5A5;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    get(4'h6, 8'hFF, 8'h00);
    foreach (SPARE[i]) begin
      bus(1'b1, 1'b0, SPARE[i], 8'hFF);
      get(SPARE[i], 8'hFF, 8'h00);
    end
    get(4'h8, 8'hFF, 8'h00);
    get(4'h9, 8'hFF, 8'h00);
    idle(2);
    $display("test reset and spare done");
    bus(1'b1, 1'b0, 4'h0, 8'h02);
    bus(1'b1, 1'b0, 4'h2, 8'hF8);
    bus(1'b1, 1'b0, 4'h3, 8'h2A);
    get(4'h2, 8'hFF, 8'hF8);
    get(4'h3, 8'hFF, 8'h2A);
    get(4'h0, 8'hFF, 8'h82);
    bus(1'b1, 1'b0, 4'h0, 8'h00);
    bus(1'b1, 1'b0, 4'h2, 8'h5C);
    get(4'h2, 8'hFF, 8'h5C);
    bus(1'b1, 1'b0, 4'h0, 8'h02);
    get(4'h2, 8'hFF, 8'hF8);
    idle(2);
    $display("test indirect done");
    for (int f = 0; f < 10; f++) begin
      s = {2'b00, FMTS[f / 2], f[0], 2'b11};
      bus(1'b1, 1'b0, 4'h8, s);
      get(4'h8, 8'hFF, s);
      get(4'h5, 8'hB0, {7'(64 - 4 * f) >= 7'h20, 2'b01, FMTS[f / 2] != chtp_pkg::FMT_LE16, 4'h0});
      put_group(1'b0, rnd());
      idle(3);
    end
    $display("test formats done");
    pulse_tick(13);
    dac_in = 16'h5A5A;
    pulse_tick(1);
    chk("dac hold", 32'(dac_out), 32'hA5A5);
    bus(1'b1, 1'b0, 4'h8, 8'h43);
    idle();
    pulse_tick(1);
    chk("dac zero", 32'(dac_out), 32'h0);
    get(4'h4, 8'h20, 8'h20);
    put_group(1'b0, rnd());
    idle(3);
    get(4'h4, 8'h20, 8'h00);
    idle(2);
    $display("test underrun done");
    bus(1'b1, 1'b0, 4'h8, 8'h01);
    idle();
    irq = 1'b1;
    @(negedge clk);
    chk("request kept", 32'(preq), 32'h1);
    bus(1'b1, 1'b0, 4'h8, 8'h81);
    idle();
    chk("request blocked", 32'(preq), 32'h0);
    irq = 1'b0;
    @(negedge clk);
    chk("request open", 32'(preq), 32'h1);
    put_group(1'b1, rnd());
    for (int b = 0; b < 4; b++) bus(1'b1, 1'b0, 4'h6, 8'h11);
    bus(1'b1, 1'b0, 4'h8, 8'h02);
    for (int b = 0; b < 4; b++) bus(1'b1, 1'b0, 4'h6, 8'h22);
    idle(4);
    $display("test playback dma done");
    bus(1'b1, 1'b0, 4'h9, 8'h83);
    get(4'h9, 8'hFF, 8'h03);
    idle();
    g = rnd();
    offer_group(g);
    get(4'h5, 8'h07, 8'h07);
    for (int b = 0; b < 5; b++) get(4'h6, 8'hFF, g[8 * (b > 3 ? 3 : b) +: 8]);
    bus(1'b1, 1'b0, 4'h9, 8'h01);
    idle();
    g = rnd();
    offer_group(g);
    chk("capture request", 32'(creq), 32'h1);
    for (int b = 0; b < 4; b++) get(4'hF, 8'hFF, g[8*b +: 8], 1'b1);
    idle(3);
    chk("capture request drop", 32'(creq), 32'h0);
    chk("capture groups taken", 32'(n_taken), 32'h2);
    chk("reads left", 32'(exp_rd_q.size()), 32'h0);
    chk("groups left", 32'(exp_grp_q.size()), 32'h0);
    $display("test capture done");
    stop_test();
  end
endmodule
